/* File: common/lvg_defs.vh */
`ifndef LVG_DEFS_VH
`define LVG_DEFS_VH
// register addresses
`define LVG_ADDR_PIN_TWO   6'h23
`define LVG_ADDR_PIN_THREE 6'h24
`define LVG_ADDR_W         6
`define LVG_DATA_W         24
// field positions
`define LVG_DIR_BIT        0
`define LVG_DIN_BIT        1
`define LVG_DOUT_BIT       2
`define LVG_HYS_BIT        3
`define LVG_DBNC_LO        4
`define LVG_INT_LO         6
`define LVG_KEEP_BIT       8
`define LVG_OD_BIT         9
`define LVG_DRIVE_BIT      10
`define LVG_PULLON_BIT     11
`define LVG_PULLKIND_LO    12
`define LVG_SLEW_LO        14
// writable mask and reset value of a control register
`define LVG_WR_MASK        24'h00fffd
`define LVG_RESET_VAL      24'h003808
// debounce times and cycle counts at 40 MHz
`define LVG_CLK_HZ         40000000
`define LVG_DBNC1_MS       10
`define LVG_DBNC2_MS       20
`define LVG_DBNC3_MS       30
`define LVG_DBNC1_CYC      ((`LVG_DBNC1_MS * `LVG_CLK_HZ) / 1000)
`define LVG_DBNC2_CYC      ((`LVG_DBNC2_MS * `LVG_CLK_HZ) / 1000)
`define LVG_DBNC3_CYC      ((`LVG_DBNC3_MS * `LVG_CLK_HZ) / 1000)
// interrupt modes
`define LVG_INT_NONE       2'h0
`define LVG_INT_FALL       2'h1
`define LVG_INT_RISE       2'h2
`define LVG_INT_BOTH       2'h3
`endif

/* File: hdl/lvg_pin.v */
`timescale 1ns/1ps
`include "lvg_defs.vh"
module lvg_pin #(
   parameter CNT_W  = 21,
   parameter DB1_CYC = `LVG_DBNC1_CYC,
   parameter DB2_CYC = `LVG_DBNC2_CYC,
   parameter DB3_CYC = `LVG_DBNC3_CYC
) (
   // clock and reset
   input  wire        clk_sys,
   input  wire        rst,
   // pad input, already synchronised
   input  wire        pad_sync,
   // configuration
   input  wire [1:0]  glitch_filter_time,
   input  wire [1:0]  int_mode,
   // results
   output reg         level,
   output reg         edge_event
);
   reg  [CNT_W-1:0] count;
   reg  [CNT_W-1:0] limit;
   wire             hit_rise;
   wire             hit_fall;
   wire             accept;

   always @* begin
      case (glitch_filter_time)
         2'h1:    limit = DB1_CYC[CNT_W-1:0];
         2'h2:    limit = DB2_CYC[CNT_W-1:0];
         2'h3:    limit = DB3_CYC[CNT_W-1:0];
         default: limit = {CNT_W{1'b0}};
      endcase
   end

   // R15 stable before accept
   assign accept   = (pad_sync != level) && ((glitch_filter_time == 2'h0) || (count >= limit - 1'b1));
   assign hit_rise = accept && pad_sync;
   assign hit_fall = accept && !pad_sync;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         count      <= {CNT_W{1'b0}};
         level      <= 1'b0;
         edge_event <= 1'b0;
      end else begin
         // R4 debounce counting
         if (pad_sync == level || accept)
            count <= {CNT_W{1'b0}};
         else
            count <= count + 1'b1;
         if (accept)
            level <= pad_sync;
         // R5 edge select
         edge_event <= (hit_rise && int_mode[1]) || (hit_fall && int_mode[0]);
      end
   end
endmodule

/* File: hdl/lvg_top.v */
`timescale 1ns/1ps
`include "lvg_defs.vh"
// What this block does
// R1 - Bit 0 selects pin direction, 0 input and 1 output, resetting to 0.
// R2 - Bit 1 reads back the sensed pin level.
// R3 - As an output the pin is driven to the level held in bit 2, which resets to 0.
// R4 - Bits 5-4 pick no debounce, 10 ms, 20 ms or 30 ms, resetting to none.
// R5 - Bits 7-6 pick no interrupt, falling, rising or both edges.
// R6 - Bit 3 selects the hysteresis receiver, resetting to 1.
// R7 - Bit 8 turns the pad keeper on, resetting to off.
// R8 - Bit 9 makes the output open drain, driving only low.
// R9 - Bit 10 selects 8 mA drive instead of 4 mA, resetting to 0.
// R10 - Bit 11 connects the pull resistor, resetting to 1.
// R11 - Bits 13-12 choose 10K/100K down or up, resetting to 100K up.
// R12 - Bits 15-14 choose the slew rate, resetting to slow.
// R13 - A second pin has an identical control register.
// R14 - Bits 23-16 read zero and ignore writes; the register reset restores defaults.
// R15 - With debounce on, level and edges change only after the pin is stable that long.
module lvg_top #(
   parameter CNT_W   = 21,
   parameter DB1_CYC = `LVG_DBNC1_CYC,
   parameter DB2_CYC = `LVG_DBNC2_CYC,
   parameter DB3_CYC = `LVG_DBNC3_CYC
) (
   // clock and reset
   input  wire                     clk_sys,
   input  wire                     rst,
   // register port
   input  wire [`LVG_ADDR_W-1:0]   reg_addr,
   input  wire                     reg_wr,
   input  wire [`LVG_DATA_W-1:0]   reg_wdata,
   output reg  [`LVG_DATA_W-1:0]   reg_rdata,
   // pins, index 0 is pin two, index 1 is pin three
   input  wire [1:0]               pad_in,
   output wire [1:0]               pad_out,
   output wire [1:0]               pad_oe,
   // pad settings
   output wire [1:0]               schmitt_select,
   output wire [1:0]               keeper_on,
   output wire [1:0]               drain_only_select,
   output wire [1:0]               drive_strength_select,
   output wire [1:0]               pull_resistor_on,
   output wire [3:0]               pull_kind_select,
   output wire [3:0]               edge_rate_select,
   // edge events towards the interrupt status logic
   output wire [1:0]               pin_edge
);
   // control storage, index 0 is pin two
   reg  [`LVG_DATA_W-1:0] ctrl [0:1];
   // pad synchroniser stages
   reg  [1:0]             sync1;
   reg  [1:0]             sync2;
   // filtered levels and address decode
   wire [1:0]             level;
   wire [1:0]             sel;
   // coded fields handed to the pin filters
   wire [1:0]             dbnc_two;
   wire [1:0]             dbnc_three;
   wire [1:0]             irq_two;
   wire [1:0]             irq_three;
   integer                i;

   // two-bit field at a given low bit, shared by every coded field of both pins
   function [1:0] field2;
      input [`LVG_DATA_W-1:0] word;
      input integer           lo;
      begin
         field2 = word[lo +: 2];
      end
   endfunction

   // a pin drives while it is an output, except for the high level in open drain
   function drive_on;
      input [`LVG_DATA_W-1:0] word;
      begin
         drive_on = word[`LVG_DIR_BIT] & (~word[`LVG_OD_BIT] | ~word[`LVG_DOUT_BIT]);
      end
   endfunction

   // read view: stored fields with the sensed level placed in the status bit
   function [`LVG_DATA_W-1:0] read_word;
      input [`LVG_DATA_W-1:0] word;
      input                   lvl;
      begin
         read_word = (word & `LVG_WR_MASK) | ({{(`LVG_DATA_W-1){1'b0}}, lvl} << `LVG_DIN_BIT);
      end
   endfunction

   assign sel[0] = (reg_addr == `LVG_ADDR_PIN_TWO);
   assign sel[1] = (reg_addr == `LVG_ADDR_PIN_THREE);

   // pad input synchroniser, first stage feeds only the second
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sync1 <= 2'h0;
         sync2 <= 2'h0;
      end else begin
         sync1 <= pad_in;
         sync2 <= sync1;
      end
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         // R14 register reset defaults
         ctrl[0] <= `LVG_RESET_VAL;
         ctrl[1] <= `LVG_RESET_VAL;
      end else begin
         for (i = 0; i < 2; i = i + 1) begin
            // R14 masked writes
            if (reg_wr && sel[i])
               ctrl[i] <= reg_wdata & `LVG_WR_MASK;
         end
      end
   end

   // R2 sensed level readback
   always @(posedge clk_sys or posedge rst) begin
      if (rst)
         reg_rdata <= {`LVG_DATA_W{1'b0}};
      else if (sel[0])
         reg_rdata <= read_word(ctrl[0], level[0]);
      else if (sel[1])
         reg_rdata <= read_word(ctrl[1], level[1]);
      else
         reg_rdata <= {`LVG_DATA_W{1'b0}};
   end

   // debounce and interrupt codes of each pin
   assign dbnc_two   = field2(ctrl[0], `LVG_DBNC_LO);
   assign dbnc_three = field2(ctrl[1], `LVG_DBNC_LO);
   assign irq_two    = field2(ctrl[0], `LVG_INT_LO);
   assign irq_three  = field2(ctrl[1], `LVG_INT_LO);

   // R13 pin two filter
   // the sensed level resets low, so a high pin gives one accepted rise after reset;
   // with the interrupt field at its reset code that rise raises no event
   lvg_pin #(
      .CNT_W   (CNT_W),
      .DB1_CYC (DB1_CYC),
      .DB2_CYC (DB2_CYC),
      .DB3_CYC (DB3_CYC)
   ) u_pin_two (
      // clock and reset
      .clk_sys            (clk_sys),
      .rst                (rst),
      // synchronised pad
      .pad_sync           (sync2[0]),
      // configuration
      .glitch_filter_time (dbnc_two),
      .int_mode           (irq_two),
      // results
      .level              (level[0]),
      .edge_event         (pin_edge[0])
   );

   // R13 pin three filter
   lvg_pin #(
      .CNT_W   (CNT_W),
      .DB1_CYC (DB1_CYC),
      .DB2_CYC (DB2_CYC),
      .DB3_CYC (DB3_CYC)
   ) u_pin_three (
      // clock and reset
      .clk_sys            (clk_sys),
      .rst                (rst),
      // synchronised pad
      .pad_sync           (sync2[1]),
      // configuration
      .glitch_filter_time (dbnc_three),
      .int_mode           (irq_three),
      // results
      .level              (level[1]),
      .edge_event         (pin_edge[1])
   );

   // R3 output level
   assign pad_out[0] = ctrl[0][`LVG_DOUT_BIT];
   assign pad_out[1] = ctrl[1][`LVG_DOUT_BIT];

   // R1 R8 direction and open drain
   assign pad_oe[0] = drive_on(ctrl[0]);
   assign pad_oe[1] = drive_on(ctrl[1]);

   // R6 receiver select
   assign schmitt_select[0] = ctrl[0][`LVG_HYS_BIT];
   assign schmitt_select[1] = ctrl[1][`LVG_HYS_BIT];

   // R7 keeper
   assign keeper_on[0] = ctrl[0][`LVG_KEEP_BIT];
   assign keeper_on[1] = ctrl[1][`LVG_KEEP_BIT];

   // R8 open drain flag to the pad
   assign drain_only_select[0] = ctrl[0][`LVG_OD_BIT];
   assign drain_only_select[1] = ctrl[1][`LVG_OD_BIT];

   // R9 drive strength
   assign drive_strength_select[0] = ctrl[0][`LVG_DRIVE_BIT];
   assign drive_strength_select[1] = ctrl[1][`LVG_DRIVE_BIT];

   // R10 pull enable
   assign pull_resistor_on[0] = ctrl[0][`LVG_PULLON_BIT];
   assign pull_resistor_on[1] = ctrl[1][`LVG_PULLON_BIT];

   // R11 pull kind
   assign pull_kind_select[1:0] = field2(ctrl[0], `LVG_PULLKIND_LO);
   assign pull_kind_select[3:2] = field2(ctrl[1], `LVG_PULLKIND_LO);

   // R12 slew rate
   assign edge_rate_select[1:0] = field2(ctrl[0], `LVG_SLEW_LO);
   assign edge_rate_select[3:2] = field2(ctrl[1], `LVG_SLEW_LO);
endmodule

/* File: test/lvg_board.sv */
`timescale 1ns/1ps
module lvg_board (
   // device side
   input  wire logic [1:0] pad_out,
   input  wire logic [1:0] pad_oe,
   input  wire logic [1:0] pull_on,
   input  wire logic [3:0] pull_kind,
   // board source
   input  wire logic [1:0] ext_en,
   input  wire logic [1:0] ext_val,
   output logic      [1:0] pad_in
);
   logic flt = 1'b0;
   // an undriven pin wanders, never a steady guess
   always #40 flt = ~flt;
   always_comb
      for (int g = 0; g < 2; g++)
         pad_in[g] = pad_oe[g] ? pad_out[g] : ext_en[g] ? ext_val[g] : pull_on[g] ? pull_kind[2*g+1] : flt;
endmodule

/* File: test/lvg_monitor.sv */
`timescale 1ns/1ps
module lvg_monitor (
   // clock and register port
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic [5:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic [23:0] reg_wdata,
   input wire logic [23:0] reg_rdata,
   // pins and pad settings
   input wire logic [1:0]  pad_out,
   input wire logic [1:0]  pad_oe,
   input wire logic [1:0]  schmitt_select,
   input wire logic [1:0]  keeper_on,
   input wire logic [1:0]  drain_only_select,
   input wire logic [1:0]  drive_strength_select,
   input wire logic [1:0]  pull_resistor_on,
   input wire logic [3:0]  pull_kind_select,
   input wire logic [3:0]  edge_rate_select
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic [23:0] wd;
   wire w2 = reg_wr && reg_addr == 6'h23;
   wire w3 = reg_wr && reg_addr == 6'h24;
   always @(posedge clk_sys) wd <= reg_wdata;
   AST_DIR: assert property (w2 |=> pad_oe[0] == (wd[0] && !(wd[9] && wd[2])))
      else $error("pin two enable wrong");
   AST_DOUT: assert property (w2 |=> pad_out[0] == wd[2])
      else $error("pin two level wrong");
   AST_OD: assert property (|(pad_oe & drain_only_select) |-> !(|(pad_oe & drain_only_select & pad_out)))
      else $error("open drain drives high");
   AST_PAD2: assert property (w2 |=> {edge_rate_select[1:0], pull_kind_select[1:0], pull_resistor_on[0],
      drive_strength_select[0], drain_only_select[0], keeper_on[0], schmitt_select[0]} == {wd[15:8], wd[3]})
      else $error("pin two pad settings wrong");
   AST_PAD3: assert property (w3 |=> {edge_rate_select[3:2], pull_kind_select[3:2], pull_resistor_on[1],
      drive_strength_select[1], drain_only_select[1], keeper_on[1], schmitt_select[1]} == {wd[15:8], wd[3]})
      else $error("pin three pad settings wrong");
   AST_HI: assert property (reg_rdata[23:16] == 8'h00)
      else $error("upper bits not zero");
   AST_UNM: assert property (!(reg_addr inside {6'h23, 6'h24}) |=> reg_rdata == 24'h0)
      else $error("unmapped read not zero");
   AST_RD: assert property ($past(reg_addr) == 6'h23 && !$past(reg_wr) |-> reg_rdata[2] == pad_out[0])
      else $error("readback disagrees with pin");
   AST_RST: assert property ($fell(rst) |-> pad_oe == 2'b00 && pull_kind_select == 4'hf && schmitt_select == 2'b11)
      else $error("reset defaults wrong");
endmodule
bind lvg_top lvg_monitor u_mon (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .pad_out, .pad_oe,
   .schmitt_select, .keeper_on, .drain_only_select, .drive_strength_select, .pull_resistor_on, .pull_kind_select,
   .edge_rate_select);

/* File: test/lvg_top_tb.sv */
`timescale 1ns/1ps
module lvg_top_tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic reg_wr = 1'b0;
   logic [5:0] reg_addr = 6'h00;
   logic [23:0] reg_wdata = 24'h0, d;
   logic [1:0] ext_en = 2'b11, ext_val = 2'b00, pad_in, pad_out, pad_oe, sch, kp, od, ds, pon, pe;
   logic [3:0] pks, srs;
   logic [23:0] reg_rdata;
   int miscompares = 0, samples_checked = 0, nedge = 0, n0;
   lvg_top #(.DB1_CYC(5), .DB2_CYC(10), .DB3_CYC(15)) u_dut (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_wdata,
      .reg_rdata, .pad_in, .pad_out, .pad_oe, .schmitt_select(sch), .keeper_on(kp), .drain_only_select(od),
      .drive_strength_select(ds), .pull_resistor_on(pon), .pull_kind_select(pks), .edge_rate_select(srs), .pin_edge(pe));
   lvg_board u_brd (.pad_out, .pad_oe, .pull_on(pon), .pull_kind(pks), .ext_en, .ext_val, .pad_in);
   initial forever #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (pe[0] === 1'b1) nedge <= nedge + 1;
   task automatic summarize();
      if (miscompares == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [23:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   // read data is registered, so look half a cycle after it lands
   task automatic rd(input logic [5:0] a, input logic [23:0] e);
      reg_addr <= a;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk(reg_rdata, e);
      @(posedge clk_sys);
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic pulse(input int n);
      ext_val[0] <= 1'b1;
      repeat (n) @(posedge clk_sys);
      ext_val[0] <= 1'b0;
      repeat (20) @(posedge clk_sys);
   endtask
   // a driven pin reads its own level, otherwise the board level
   function automatic logic [23:0] expv(input logic [23:0] v, input logic e);
      expv = (v & 24'h00fffd) | {22'h0, (v[0] && !(v[9] && v[2])) ? v[2] : e, 1'b0};
   endfunction
   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      summarize();
   end
   initial begin
      void'($urandom(32'he40db134));
      do_reset();
      rd(6'h23, 24'h003808);
      rd(6'h24, 24'h003808);
      for (int i = 0; i < 24; i++) begin
         d = 24'($urandom);
         ext_val <= 2'($urandom);
         wr(6'h23 + 6'(i[0]), d);
         repeat (25) @(posedge clk_sys);
         rd(6'h23 + 6'(i[0]), expv(d, ext_val[i[0]]));
      end
      ext_val <= 2'b00;
      repeat (25) @(posedge clk_sys);
      wr(6'h25, 24'hffffff);
      rd(6'h25, 24'h0);
      rd(6'h22, 24'h0);
      for (int m = 0; m < 4; m++) begin
         wr(6'h23, 24'(m) << 6);
         n0 = nedge;
         pulse(8);
         chk(24'(nedge - n0), 24'(m[1]) + 24'(m[0]));
      end
      for (int c = 1; c < 4; c++) begin
         wr(6'h23, 24'hc0 | (24'(c) << 4));
         n0 = nedge;
         pulse(5 * c - 2);
         chk(24'(nedge - n0), 24'h0);
         pulse(5 * c + 3);
         chk(24'(nedge - n0), 24'h2);
      end
      // pin three left to its pull resistor by the board
      ext_en <= 2'b01;
      wr(6'h24, 24'h003808);
      repeat (25) @(posedge clk_sys);
      rd(6'h24, 24'h00380a);
      wr(6'h24, 24'h000808);
      repeat (25) @(posedge clk_sys);
      rd(6'h24, 24'h000808);
      ext_en <= 2'b11;
      do_reset();
      rd(6'h23, 24'h003808);
      summarize();
   end
endmodule
